/* logic/tcs_top.sv */
// test-class trigger sequencer: software request, bunch-crossing wait, level-0/1/2 stages
// assumes pin inputs are asynchronous to CLK; registers reached over axi4-lite
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module tcs_top
	import tcs_pkg::*;
(
	input wire logic CLK, // bunch-crossing clock
	input wire logic RESETN, // async reset, active low
	input wire logic [7:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // byte strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic S_AXI_BVALID, // write response valid
	output logic [1:0] S_AXI_BRESP, // write response
	input wire logic S_AXI_BREADY, // response ready
	input wire logic [7:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic S_AXI_RVALID, // read data valid
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	input wire logic S_AXI_RREADY, // read ready
	input wire logic BC_START, // first bunch crossing of orbit
	input wire logic [TCS_NDET-1:0] DET_BUSY, // per-detector busy
	input wire logic ACQUISITION_BUSY, // acquisition busy
	input wire logic PROC_BUSY, // processor busy
	input wire logic PROC_DEAD, // processor dead time
	input wire logic [2:0] PROT_IN, // dedicated protection outputs per level
	output logic TRIGGER_LEVEL_ZERO, // test level-zero trigger
	output logic PHYS_L0_VETO, // veto to physics level zero
	output logic TRIGGER_LEVEL_ONE, // test level-one trigger
	output logic LEVEL_TWO_ACCEPT, // test level-two accept
	output logic LEVEL_TWO_REJECT, // test level-two reject
	output logic [TCS_NDET-1:0] DET_ACCEPT, // accept message per detector
	output logic [TCS_NDET-1:0] DET_REJECT, // reject word per detector
	output logic [3:0] READOUT_CTRL, // readout bits with the decision
	output logic PRE_PULSE // calibration pre-pulse
);
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] sys;
		logic [TCS_NDET-1:0] det;
		logic [31:0] rdo;
		logic [31:0] notrig;
		logic req_w;
		logic req;
		logic busy;
		logic ack0;
		logic ack1;
		logic ack2a;
		logic ack2r;
		tcs_state_t st;
		logic [TCS_BC_W-1:0] bc;
		logic [TCS_CNT_W-1:0] cnt;
		logic [1:0] s_start;
		logic [TCS_NDET-1:0] s_det0, s_det1;
		logic [1:0] s_acq, s_pb, s_pd;
		logic [2:0] s_pr0, s_pr1;
		logic l0, l1, l2a, l2r, pre;
		logic [TCS_NDET-1:0] dacc, drej;
		logic [3:0] rc;
	} tcs_core_t;
	tcs_core_t c_r, c_nxt;

	logic wr_stb, wr_ok, rd_ok;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_word;
	logic [3:0] wr_be;
	logic cluster_busy, hit, l0_ok;
	logic [TCS_BC_W-1:0] bc_goal;
	logic [3:0] rc_sel;

	tcs_axil u_bus (
		.clk(CLK),
		.resetn(RESETN),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bvalid(S_AXI_BVALID),
		.bresp(S_AXI_BRESP),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rvalid(S_AXI_RVALID),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rready(S_AXI_RREADY),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_be(wr_be),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_word(rd_word),
		.rd_ok(rd_ok)
	);

	// address decode for both directions; writes also refuse the read-only status register
	always_comb begin
		wr_ok = (wr_addr <= TCS_OFF_NOTRIG) && (wr_addr[1:0] == 2'b00) && (wr_addr != TCS_OFF_STAT);
		rd_ok = (rd_addr <= TCS_OFF_NOTRIG) && (rd_addr[1:0] == 2'b00);
		case (rd_addr)
			TCS_OFF_CFG: rd_word = c_r.cfg;
			TCS_OFF_SYS: rd_word = c_r.sys;
			TCS_OFF_DET: rd_word = {{(32-TCS_NDET){1'b0}}, c_r.det};
			TCS_OFF_RDO: rd_word = c_r.rdo;
			TCS_OFF_STAT: rd_word = {26'h000_0000, c_r.ack2r, c_r.ack2a, c_r.ack1, c_r.ack0, c_r.busy, c_r.req};
			TCS_OFF_NOTRIG: rd_word = c_r.notrig;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// test cluster busy: any participating detector busy
	assign cluster_busy = |(c_r.s_det1 & c_r.det);
	// target crossing: calibration bc in calib mode, else programmed bc
	assign bc_goal = c_r.cfg[TCS_CFG_CALIB] ? c_r.sys[TCS_BC_W+15:16] : c_r.cfg[TCS_CFG_BC_LSB +: TCS_BC_W];
	// no-trigger mask is coarse: bit n covers crossings with bc top bits equal n
	assign hit = (c_r.cfg[TCS_CFG_SYNC] || c_r.cfg[TCS_CFG_CALIB]) ? (c_r.bc == bc_goal)
		: !c_r.notrig[c_r.bc[TCS_BC_W-1:TCS_BC_W-5]];
	// level-zero vetoes, all must be off
	assign l0_ok = !(c_r.cfg[TCS_CFG_PROT0] && c_r.s_pr1[0]) && !cluster_busy && !c_r.s_acq[1]
		&& !c_r.s_pb[1] && !c_r.s_pd[1];

	// readout bits of the first participating detector, four per detector
	always_comb begin
		rc_sel = 4'h0;
		for (int i = TCS_NDET - 1; i >= 0; i--) begin
			if (c_r.det[i])
				rc_sel = c_r.rdo[i*4 +: 4];
		end
	end

	// sequence and register updates
	always_comb begin
		c_nxt = c_r;
		c_nxt.l0 = 1'b0;
		c_nxt.l1 = 1'b0;
		c_nxt.l2a = 1'b0;
		c_nxt.l2r = 1'b0;
		c_nxt.pre = 1'b0;
		c_nxt.dacc = '0;
		c_nxt.drej = '0;
		// two-flop synchronisers on pins
		c_nxt.s_start = {c_r.s_start[0], BC_START};
		c_nxt.s_det0 = DET_BUSY;
		c_nxt.s_det1 = c_r.s_det0;
		c_nxt.s_acq = {c_r.s_acq[0], ACQUISITION_BUSY};
		c_nxt.s_pb = {c_r.s_pb[0], PROC_BUSY};
		c_nxt.s_pd = {c_r.s_pd[0], PROC_DEAD};
		c_nxt.s_pr0 = PROT_IN;
		c_nxt.s_pr1 = c_r.s_pr0;
		// bunch-crossing counter, reloaded at orbit start
		if (c_r.s_start[1] || c_r.bc == TCS_BC_LAST)
			c_nxt.bc = '0;
		else
			c_nxt.bc = c_r.bc + 1'b1;
		c_nxt.req_w = 1'b0;
		// host writes; data of request and clear writes is ignored
		if (wr_stb && wr_ok) begin
			case (wr_addr)
				TCS_OFF_CFG: c_nxt.cfg = wr_data;
				TCS_OFF_SYS: c_nxt.sys = wr_data;
				TCS_OFF_DET: c_nxt.det = wr_data[TCS_NDET-1:0];
				TCS_OFF_RDO: c_nxt.rdo = wr_data;
				TCS_OFF_NOTRIG: c_nxt.notrig = wr_data;
				TCS_OFF_REQ: c_nxt.req_w = 1'b1;
				TCS_OFF_CLR: begin
					c_nxt.ack0 = 1'b0;
					c_nxt.ack1 = 1'b0;
					c_nxt.ack2a = 1'b0;
					c_nxt.ack2r = 1'b0;
					c_nxt.busy = 1'b0;
				end
				default: ;
			endcase
		end
		// request registered once more before use, set wins over clear
		if (c_r.req_w) begin
			c_nxt.req = 1'b1;
			c_nxt.busy = 1'b1;
		end
		case (c_r.st)
			TS_IDLE: begin
				if (c_r.req)
					c_nxt.st = c_r.cfg[TCS_CFG_CALIB] ? TS_PRE : TS_WAIT;
			end
			TS_PRE: begin
				// pre-pulse at its crossing, then wait for calibration bc
				if (c_r.bc == c_r.sys[TCS_BC_W-1:0]) begin
					c_nxt.pre = 1'b1;
					c_nxt.st = TS_WAIT;
				end
			end
			TS_WAIT: begin
				if (hit) begin
					// attempt made: request clears whatever the outcome
					c_nxt.req = c_r.req_w;
					c_nxt.cnt = '0;
					if (l0_ok) begin
						c_nxt.l0 = 1'b1;
						c_nxt.ack0 = 1'b1;
						c_nxt.st = TS_L1;
					end else begin
						c_nxt.st = TS_IDLE;
					end
				end
			end
			TS_L1: begin
				c_nxt.cnt = c_r.cnt + 1'b1;
				if (c_r.cnt == TCS_CNT_W'(TCS_L1_CYC - 1)) begin
					c_nxt.cnt = '0;
					if (!(c_r.cfg[TCS_CFG_PROT1] && c_r.s_pr1[1])) begin
						c_nxt.l1 = 1'b1;
						c_nxt.ack1 = 1'b1;
						c_nxt.st = TS_L2;
					end else begin
						c_nxt.st = TS_IDLE;
					end
				end
			end
			TS_L2: begin
				c_nxt.cnt = c_r.cnt + 1'b1;
				if (c_r.cnt == TCS_CNT_W'(TCS_L2_CYC - 1)) begin
					c_nxt.st = TS_IDLE;
					c_nxt.rc = rc_sel;
					if (!(c_r.cfg[TCS_CFG_PROT2] && c_r.s_pr1[2])) begin
						c_nxt.l2a = 1'b1;
						c_nxt.ack2a = 1'b1;
						c_nxt.dacc = c_r.det;
					end else begin
						c_nxt.l2r = 1'b1;
						c_nxt.ack2r = 1'b1;
						c_nxt.drej = c_r.det;
					end
				end
			end
			default: c_nxt.st = TS_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			c_r <= '0;
			c_r.cfg <= TCS_RST_CFG;
		end else begin
			c_r <= c_nxt;
		end
	end

	// outputs straight from flops; veto is the level-zero flop itself
	assign TRIGGER_LEVEL_ZERO = c_r.l0;
	assign PHYS_L0_VETO = c_r.l0;
	assign TRIGGER_LEVEL_ONE = c_r.l1;
	assign LEVEL_TWO_ACCEPT = c_r.l2a;
	assign LEVEL_TWO_REJECT = c_r.l2r;
	assign DET_ACCEPT = c_r.dacc;
	assign DET_REJECT = c_r.drej;
	assign READOUT_CTRL = c_r.rc;
	assign PRE_PULSE = c_r.pre;

	// level one follows level zero by exactly the level-one latency
	a_l1_after_l0: assert property (@(posedge CLK) disable iff (!RESETN)
		TRIGGER_LEVEL_ONE |-> c_r.ack0 && $past(TRIGGER_LEVEL_ZERO, TCS_L1_CYC))
		else $error("level one without level zero");

	// level-two decision follows level one by exactly the level-two latency
	a_l2_after_l1: assert property (@(posedge CLK) disable iff (!RESETN)
		LEVEL_TWO_ACCEPT || LEVEL_TWO_REJECT |-> c_r.ack1 && $past(TRIGGER_LEVEL_ONE, TCS_L2_CYC))
		else $error("level two without level one");
	a_accept_reject: assert property (@(posedge CLK) disable iff (!RESETN)
		!(LEVEL_TWO_ACCEPT && LEVEL_TWO_REJECT)) else $error("accept and reject together");

	// cluster and acquisition busy block level zero
	a_l0_vetoes: assert property (@(posedge CLK) disable iff (!RESETN)
		c_r.st == TS_WAIT && hit && (cluster_busy || c_r.s_acq[1]) |=> !TRIGGER_LEVEL_ZERO)
		else $error("level zero despite busy");
	// processor busy, dead time and enabled level-zero protection block it as well
	a_l0_proc_veto: assert property (@(posedge CLK) disable iff (!RESETN)
		c_r.st == TS_WAIT && hit && (c_r.s_pb[1] || c_r.s_pd[1] || (c_r.cfg[TCS_CFG_PROT0] && c_r.s_pr1[0]))
		|=> !TRIGGER_LEVEL_ZERO) else $error("level zero despite processor veto");

	// request and busy flags follow the request write and the attempt
	a_req_busy: assert property (@(posedge CLK) disable iff (!RESETN)
		c_r.req_w |=> c_r.busy && c_r.req) else $error("request did not set busy");
	a_req_clear: assert property (@(posedge CLK) disable iff (!RESETN)
		c_r.st == TS_WAIT && hit && !c_r.req_w |=> !c_r.req) else $error("request not cleared");
	// a level-zero pulse only ever answers a pending request, and leaves its flag set
	a_l0_has_req: assert property (@(posedge CLK) disable iff (!RESETN)
		TRIGGER_LEVEL_ZERO |-> $past(c_r.req) && c_r.ack0) else $error("level zero without request");
	// host clear drops busy unless a new request lands in the same cycle
	a_clear_busy: assert property (@(posedge CLK) disable iff (!RESETN)
		wr_stb && wr_ok && wr_addr == TCS_OFF_CLR && !c_r.req_w |=> !c_r.busy)
		else $error("clear write left busy set");

	// decision fan-out to the participating detectors
	a_ack_l2: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(LEVEL_TWO_ACCEPT) |-> c_r.ack2a && DET_ACCEPT == c_r.det) else $error("accept ack missing");
	a_rej_l2: assert property (@(posedge CLK) disable iff (!RESETN)
		LEVEL_TWO_REJECT |-> c_r.ack2r && DET_REJECT == c_r.det && DET_ACCEPT == '0)
		else $error("reject word missing");

	// a vetoed level one ends the sequence at once
	a_veto_stop: assert property (@(posedge CLK) disable iff (!RESETN)
		c_r.st == TS_L1 && c_r.cnt == TCS_CNT_W'(TCS_L1_CYC - 1) && c_r.cfg[TCS_CFG_PROT1] && c_r.s_pr1[1]
		|=> !TRIGGER_LEVEL_ONE && c_r.st == TS_IDLE) else $error("vetoed stage continued");
	a_veto_phys: assert property (@(posedge CLK) disable iff (!RESETN)
		TRIGGER_LEVEL_ZERO |-> PHYS_L0_VETO) else $error("physics veto missing");

	// synchronous trigger lands on the programmed crossing
	a_sync_bc: assert property (@(posedge CLK) disable iff (!RESETN)
		TRIGGER_LEVEL_ZERO && c_r.cfg[TCS_CFG_SYNC] && !c_r.cfg[TCS_CFG_CALIB]
		|-> $past(c_r.bc) == c_r.cfg[TCS_CFG_BC_LSB +: TCS_BC_W]) else $error("sync trigger off its crossing");
	// calibration pre-pulse and trigger land on their system crossings
	a_calib_bc: assert property (@(posedge CLK) disable iff (!RESETN)
		TRIGGER_LEVEL_ZERO && c_r.cfg[TCS_CFG_CALIB] |-> $past(c_r.bc) == c_r.sys[TCS_BC_W+15:16])
		else $error("calibration trigger off its crossing");
	a_pre_bc: assert property (@(posedge CLK) disable iff (!RESETN)
		PRE_PULSE |-> $past(c_r.bc) == c_r.sys[TCS_BC_W-1:0]) else $error("pre-pulse off its crossing");
	// asynchronous trigger never lands on a masked crossing
	a_async_mask: assert property (@(posedge CLK) disable iff (!RESETN)
		TRIGGER_LEVEL_ZERO && !c_r.cfg[TCS_CFG_SYNC] && !c_r.cfg[TCS_CFG_CALIB]
		|-> !$past(c_r.notrig[c_r.bc[TCS_BC_W-1:TCS_BC_W-5]])) else $error("async trigger on masked crossing");
endmodule

/* logic/tcs_pkg.sv */
// package for the test-class trigger sequencer: register map, field layout, timing counts
// assumes a 32-bit axi4-lite register bus and one bunch-crossing clock domain
package tcs_pkg;
	// register byte offsets (all word aligned)
	localparam logic [7:0] TCS_OFF_CFG = 8'h00;
	localparam logic [7:0] TCS_OFF_SYS = 8'h04;
	localparam logic [7:0] TCS_OFF_DET = 8'h08;
	localparam logic [7:0] TCS_OFF_RDO = 8'h0C;
	localparam logic [7:0] TCS_OFF_REQ = 8'h10;
	localparam logic [7:0] TCS_OFF_CLR = 8'h14;
	localparam logic [7:0] TCS_OFF_STAT = 8'h18;
	localparam logic [7:0] TCS_OFF_NOTRIG = 8'h1C;
	// configuration field positions
	localparam int TCS_CFG_SYNC = 0;
	localparam int TCS_CFG_CALIB = 1;
	localparam int TCS_CFG_PROT0 = 2;
	localparam int TCS_CFG_PROT1 = 3;
	localparam int TCS_CFG_PROT2 = 4;
	localparam int TCS_CFG_BC_LSB = 16;
	// status field positions
	localparam int TCS_ST_REQ = 0;
	localparam int TCS_ST_BUSY = 1;
	localparam int TCS_ST_ACK0 = 2;
	localparam int TCS_ST_ACK1 = 3;
	localparam int TCS_ST_ACK2A = 4;
	localparam int TCS_ST_ACK2R = 5;
	// sizes
	localparam int TCS_BC_W = 12;
	localparam int TCS_NDET = 8;
	localparam int TCS_ORBIT_BC = 3564;
	localparam logic [TCS_BC_W-1:0] TCS_BC_LAST = TCS_BC_W'(TCS_ORBIT_BC - 1);
	localparam logic [31:0] TCS_RST_CFG = 32'h0000_0000;
	// level-0 to level-1 and level-1 to level-2 latencies
	localparam int TCS_L1_LAT_NS = 1200;
	localparam int TCS_L2_LAT_NS = 1000;
	localparam int TCS_CLK_NS = 5;
	localparam int TCS_L1_CYC = (TCS_L1_LAT_NS + TCS_CLK_NS - 1) / TCS_CLK_NS;
	localparam int TCS_L2_CYC = (TCS_L2_LAT_NS + TCS_CLK_NS - 1) / TCS_CLK_NS;
	localparam int TCS_CNT_W = 10;
	// sequence states, gray along idle-wait-l1-l2-idle; the calibration detour is off that path
	typedef enum logic [2:0] {
		TS_IDLE = 3'b000,
		TS_WAIT = 3'b001,
		TS_L1 = 3'b011,
		TS_L2 = 3'b010,
		TS_PRE = 3'b100
	} tcs_state_t;
endpackage

/* logic/tcs_axil.sv */
// axi4-lite slave front end: holds handshakes, emits a one-cycle write strobe; read address passes straight through
// assumes the parent answers read data combinationally from its registers
`timescale 1ns/1ps
module tcs_axil
	import tcs_pkg::*;
(
	input wire logic clk, // bus clock
	input wire logic resetn, // async reset, active low
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic bvalid, // write response valid
	output logic [1:0] bresp, // write response
	input wire logic bready, // response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic rvalid, // read data valid
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	input wire logic rready, // read ready
	output logic wr_stb, // one-cycle write strobe
	output logic [7:0] wr_addr, // write address
	output logic [31:0] wr_data, // write data
	output logic [3:0] wr_be, // byte enables
	input wire logic wr_ok, // write address is mapped
	output logic [7:0] rd_addr, // read address, passed straight from araddr
	input wire logic [31:0] rd_word, // read word from parent
	input wire logic rd_ok // read address is mapped
);
	typedef struct packed {
		logic aw_h;
		logic w_h;
		logic [7:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic stb;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} tcs_axs_t;
	tcs_axs_t s_r, s_nxt;

	// capture address and data in either order; respond once both are held
	always_comb begin
		s_nxt = s_r;
		s_nxt.stb = 1'b0;
		if (awvalid && !s_r.aw_h && !s_r.bv) begin
			s_nxt.aw_h = 1'b1;
			s_nxt.awa = awaddr;
		end
		if (wvalid && !s_r.w_h && !s_r.bv) begin
			s_nxt.w_h = 1'b1;
			s_nxt.wd = wdata;
			s_nxt.ws = wstrb;
		end
		if (s_r.aw_h && s_r.w_h) begin
			s_nxt.aw_h = 1'b0;
			s_nxt.w_h = 1'b0;
			s_nxt.stb = 1'b1;
			s_nxt.bv = 1'b1;
			s_nxt.br = wr_ok ? 2'h0 : 2'h2;
		end
		if (s_r.bv && bready)
			s_nxt.bv = 1'b0;
		// reads answer one cycle after the address is taken
		if (arvalid && !s_r.rv) begin
			s_nxt.rv = 1'b1;
			s_nxt.rd = rd_ok ? rd_word : 32'h0000_0000;
			s_nxt.rr = rd_ok ? 2'h0 : 2'h2;
		end else if (s_r.rv && rready) begin
			s_nxt.rv = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign awready = !s_r.aw_h && !s_r.bv;
	assign wready = !s_r.w_h && !s_r.bv;
	assign bvalid = s_r.bv;
	assign bresp = s_r.br;
	assign arready = !s_r.rv;
	assign rd_addr = araddr;
	assign rvalid = s_r.rv;
	assign rdata = s_r.rd;
	assign rresp = s_r.rr;
	assign wr_stb = s_r.stb;
	assign wr_addr = s_r.awa;
	assign wr_data = s_r.wd;
	assign wr_be = s_r.ws;
endmodule

/* tb/tcs_host.sv */
// host-side model: axi4-lite master that sets up the test class and requests triggers
// assumes one clock; every task begins just after a rising edge and drives by nba
`timescale 1ns/1ps
module tcs_host
	import tcs_pkg::*;
(
	input wire logic clk, // bus clock
	output logic [7:0] awaddr, // write address
	output logic awvalid, // write address valid
	input wire logic awready, // write address ready
	output logic [31:0] wdata, // write data
	output logic [3:0] wstrb, // byte strobes
	output logic wvalid, // write data valid
	input wire logic wready, // write data ready
	input wire logic bvalid, // write response valid
	input wire logic [1:0] bresp, // write response
	output logic bready, // write response ready
	output logic [7:0] araddr, // read address
	output logic arvalid, // read address valid
	input wire logic arready, // read address ready
	input wire logic rvalid, // read data valid
	input wire logic [31:0] rdata, // read data
	input wire logic [1:0] rresp, // read response
	output logic rready, // read ready
	output logic hang // a transfer never got its answer
);
	// idle bus from time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hang} = '0;
	end

	// address and data offered together, each dropped once taken; bounded wait for the answer
	// handshakes are sampled at the falling edge, where the slave's flops have settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw_t, w_t, b_t;
		n = 0;
		b_t = 1'b0;
		r = 2'b00;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid && bready;
			r = bresp;
			@(posedge clk);
			n++;
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while (!b_t && n < 200);
		bready <= 1'b0;
		if (!b_t) hang <= 1'b1;
	endtask

	// read: rready held until rvalid is seen; data taken with the handshake
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar_t, r_t;
		n = 0;
		r_t = 1'b0;
		d = 32'h0000_0000;
		r = 2'b00;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ar_t = arvalid && arready;
			r_t = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge clk);
			n++;
			if (ar_t) arvalid <= 1'b0;
		end while (!r_t && n < 200);
		rready <= 1'b0;
		if (!r_t) hang <= 1'b1;
	endtask

	// request write; the value is junk on purpose so no meaning can creep in
	task automatic trig(input logic [31:0] junk);
		logic [1:0] r;
		wr(TCS_OFF_REQ, junk, r);
	endtask

	// one dummy write drops every acknowledge, both level-two flags together, and busy
	task automatic clear_all();
		logic [1:0] r;
		wr(TCS_OFF_CLR, 32'hA5A5_5A5A, r);
	endtask
endmodule

/* tb/tcs_top_tb.sv */
// bench for the test-class trigger sequencer: bus traffic, busy/protection pins, pulse checks
// assumes tcs_host as bus master and an orbit marker made here every orbit
`timescale 1ns/1ps
module tcs_top_tb
	import tcs_pkg::*;
;
	localparam logic [31:0] SY = 32'h0000_0001 << TCS_CFG_SYNC, CA = 32'h0000_0001 << TCS_CFG_CALIB;
	localparam logic [31:0] P0 = 32'h0000_0001 << TCS_CFG_PROT0, P1 = 32'h0000_0001 << TCS_CFG_PROT1;
	localparam logic [31:0] P2 = 32'h0000_0001 << TCS_CFG_PROT2, SB = 32'h0000_0001 << TCS_ST_BUSY;
	localparam logic [31:0] S0 = 32'h0000_0001 << TCS_ST_ACK0, S1 = 32'h0000_0001 << TCS_ST_ACK1;
	localparam logic [31:0] SA = 32'h0000_0001 << TCS_ST_ACK2A, SR = 32'h0000_0001 << TCS_ST_ACK2R;
	localparam logic [31:0] OK = SB | S0 | S1 | SA;
	localparam logic [4:0] EP = 5'h10, E0 = 5'h08, E1 = 5'h04, EA = 5'h02, ER = 5'h01;
	localparam int PB = 32'h0000_0BB8, CB = 32'h0000_0DAC;
	logic clk, resetn, hang, acquisition_busy, proc_busy, proc_dead, l0, veto, l1, l2a, l2r, pre;
	logic bc_start = 1'b0;
	logic [TCS_NDET-1:0] det_busy, det_acc, det_rej;
	logic [2:0] prot_in;
	logic [7:0] awaddr, araddr, cur_det;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, rdo;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [4:0] ev;
	logic [4:0] pq[$];
	logic [33:0] rq[$];
	logic [31:0] seed = 32'h0000_4AF7;
	logic [11:0] b[2];
	int n_mismatch = 0, tests_run = 0, cyc = 0, bcc = 0, t0, t1, tp, ts[2];

	tcs_top dut_u (.CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BVALID(bvalid), .S_AXI_BRESP(bresp), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RVALID(rvalid),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RREADY(rready), .BC_START(bc_start),
		.DET_BUSY(det_busy), .ACQUISITION_BUSY(acquisition_busy), .PROC_BUSY(proc_busy),
		.PROC_DEAD(proc_dead), .PROT_IN(prot_in), .TRIGGER_LEVEL_ZERO(l0), .PHYS_L0_VETO(veto),
		.TRIGGER_LEVEL_ONE(l1), .LEVEL_TWO_ACCEPT(l2a), .LEVEL_TWO_REJECT(l2r), .DET_ACCEPT(det_acc),
		.DET_REJECT(det_rej), .READOUT_CTRL(rdo), .PRE_PULSE(pre));

	tcs_host host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
		.rresp(rresp), .rready(rready), .hang(hang));

	// 200 MHz bunch-crossing clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// orbit marker: exact period, so crossing numbers repeat every orbit
	always @(posedge clk) begin
		bcc <= (bcc == TCS_ORBIT_BC - 1) ? 0 : bcc + 1;
		bc_start <= (bcc == 0);
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int md(input int x);
		return ((x % TCS_ORBIT_BC) + TCS_ORBIT_BC) % TCS_ORBIT_BC;
	endfunction

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// a bus transfer that never finished ends the run
	always @(posedge clk) if (hang === 1'b1) begin
		n_mismatch++;
		wrap_up();
	end

	// read results: oldest note against each read answer; polling reads carry no note
	// sampled at the falling edge, so the answer is settled and still standing
	always @(negedge clk) if (rvalid && rready && rq.size() > 0) chk({rresp, rdata}, rq.pop_front());

	// pulse watcher: order against notes, then the stage spacing and detector fan-out
	always @(negedge clk) begin
		cyc++;
		ev = {pre, l0, l1, l2a, l2r};
		if (ev !== 5'h0) begin
			chk(34'(ev), pq.size() > 0 ? 34'(pq.pop_front()) : 34'h0);
			if (pre === 1'b1) tp = cyc;
			if (l0 === 1'b1) begin
				t0 = cyc;
				chk(34'(veto), 34'h1);
			end
			if (l1 === 1'b1) begin
				chk(34'(cyc - t0), 34'(TCS_L1_CYC));
				t1 = cyc;
			end
			if (l2a === 1'b1 || l2r === 1'b1) begin
				chk(34'(cyc - t1), 34'(TCS_L2_CYC));
				chk({18'h0, det_acc, det_rej}, {18'h0, l2a ? cur_det : 8'h0, l2r ? cur_det : 8'h0});
			end
		end
	end

	task automatic rd_exp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [31:0] x;
		logic [1:0] y;
		rq.push_back({e, d});
		host_u.rd(a, x, y);
	endtask

	// poll until the attempt is made, then let the level-one and level-two times pass before judging
	task automatic wait_attempt();
		logic [31:0] s;
		logic [1:0] y;
		int n;
		n = 0;
		repeat (4) @(posedge clk);
		do begin
			host_u.rd(TCS_OFF_STAT, s, y);
			n++;
		end while (s[TCS_ST_REQ] !== 1'b0 && n < 1500);
		if (s[TCS_ST_REQ] !== 1'b0) begin
			n_mismatch++;
			wrap_up();
		end
		repeat (600) @(posedge clk);
		chk(34'(pq.size()), 34'h0);
	endtask

	// one full software trigger: set up class, request, judge flags, clear
	task automatic seq(input logic [31:0] cfg, input logic [7:0] det, input logic [19:0] evs, input logic [31:0] st);
		logic [31:0] ro;
		int lo;
		ro = rnd();
		lo = 0;
		for (int i = 3; i >= 0; i--) if (evs[i*5 +: 5] != 5'h0) pq.push_back(evs[i*5 +: 5]);
		for (int i = TCS_NDET - 1; i >= 0; i--) if (det[i]) lo = i;
		cur_det = det;
		host_u.wr(TCS_OFF_CFG, cfg, r);
		host_u.wr(TCS_OFF_DET, {24'h0, det}, r);
		host_u.wr(TCS_OFF_RDO, ro, r);
		host_u.trig(rnd());
		wait_attempt();
		rd_exp(TCS_OFF_STAT, st, 2'b00);
		if (st[TCS_ST_ACK2A] || st[TCS_ST_ACK2R]) chk({30'h0, rdo}, {30'h0, ro[lo*4 +: 4]});
		host_u.clear_all(); // busy dropped before any next request
		rd_exp(TCS_OFF_STAT, 32'h0, 2'b00);
	endtask

	// main sequence
	initial begin
		{resetn, acquisition_busy, proc_busy, proc_dead} = '0;
		det_busy = '0;
		prot_in = '0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		rd_exp(TCS_OFF_STAT, 32'h0, 2'b00);
		rd_exp(TCS_OFF_CFG, TCS_RST_CFG, 2'b00);
		rd_exp(8'h20, 32'h0, 2'b10);
		host_u.wr(TCS_OFF_STAT, rnd(), r);
		chk({32'h0, r}, {32'h0, 2'b10});
		// all protections enabled but quiet: accept path
		seq(P0 | P1 | P2, 8'(rnd()) | 8'h80, {E0, E1, EA, 5'h0}, OK);
		prot_in <= 3'b100;
		seq(P2, 8'(rnd()) | 8'h10, {E0, E1, ER, 5'h0}, SB | S0 | S1 | SR);
		prot_in <= 3'b010;
		seq(P1, 8'(rnd()) | 8'h02, {E0, 15'h0}, SB | S0);
		// level-zero vetoes one by one; the last case is busy on a non-participant only
		for (int i = 0; i < 6; i++) begin
			det_busy <= (i == 0) ? 8'h02 : (i == 5) ? 8'h80 : 8'h00;
			acquisition_busy <= (i == 1);
			proc_busy <= (i == 2);
			proc_dead <= (i == 3);
			prot_in <= {2'b00, i == 4};
			@(posedge clk);
			seq(P0, 8'h03, i == 5 ? {E0, E1, EA, 5'h0} : 20'h0, i == 5 ? OK : SB);
		end
		det_busy <= '0;
		prot_in <= '0;
		// synchronous at two random crossings: firing times keep the crossing difference
		for (int i = 0; i < 2; i++) begin
			b[i] = 12'(md(int'(rnd() & 32'h0000_0FFF)));
			seq(SY | (32'(b[i]) << TCS_CFG_BC_LSB), 8'(rnd()) | 8'h01, {E0, E1, EA, 5'h0}, OK);
			ts[i] = t0;
		end
		chk(34'(md(ts[1] - ts[0])), 34'(md(int'(b[1]) - int'(b[0]))));
		// calibration: pre-pulse then trigger, one detector only
		host_u.wr(TCS_OFF_SYS, (32'(CB) << 16) | 32'(PB), r);
		seq(CA, 8'h04, {EP, E0, E1, EA}, OK);
		chk(34'(t0 - tp), 34'(CB - PB));
		// asynchronous with only window 5 open, against a synchronous reference at its start
		seq(SY | (32'h0000_0280 << TCS_CFG_BC_LSB), 8'h01, {E0, E1, EA, 5'h0}, OK);
		ts[0] = t0;
		host_u.wr(TCS_OFF_NOTRIG, ~(32'h0000_0001 << 5), r);
		seq(32'h0, 8'h01, {E0, E1, EA, 5'h0}, OK);
		chk(34'(md(t0 - ts[0])), 34'h0);
		wrap_up();
	end
endmodule
